// ### hdl/ext_bus_defs.vh
// Constants for the external bus cycle sequencer
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// Cycle kinds
`define BC_KIND_CODE   2'h0
`define BC_KIND_READ   2'h1
`define BC_KIND_WRITE  2'h2

// All timing is counted in half bus clocks; one core clock is one half bus clock
`define BC_HS_W        5
`define BC_ZERO        5'h00
`define BC_HALF        5'h01
`define BC_CLK_HS      5'h02
`define BC_SEQ_BASE    5'h02
`define BC_LAT_BASE    5'h04
`define BC_WR_BASE     5'h04
`define BC_ALE_NARROW  5'h01
`define BC_ALE_WIDE    5'h03
`define BC_WSTB_NARROW 5'h02
`define BC_WSTB_WIDE   5'h04
`define BC_WAIT_MIN    5'h02

// State codes, one-hot
`define BC_ST_IDLE     2'h1
`define BC_ST_RUN      2'h2

`endif

// ### hdl/bus_sync2.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bus_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // bus_sync2

// ### hdl/bus_cycle_calc.v
// Half-clock timing points of one bus cycle from its kind and the timing settings
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module bus_cycle_calc (
  input  wire [1:0]           kind,
  input  wire                 latch,
  input  wire                 ale_sel,
  input  wire [1:0]           code_seq,
  input  wire [1:0]           code_lat,
  input  wire [1:0]           read_seq,
  input  wire [1:0]           read_lat,
  input  wire [1:0]           write_seq,
  input  wire [1:0]           write_lat,
  input  wire                 hold_ext,
  input  wire                 wstb_sel,
  output reg  [`BC_HS_W-1:0]  tot,
  output reg  [`BC_HS_W-1:0]  ale_end,
  output reg  [`BC_HS_W-1:0]  stb_start,
  output reg  [`BC_HS_W-1:0]  stb_end,
  output reg  [`BC_HS_W-1:0]  data_start,
  output reg                  wait_ok
);
  reg [1:0]          len;
  reg [`BC_HS_W-1:0] len_hs;
  reg [`BC_HS_W-1:0] hold;
  reg [`BC_HS_W-1:0] wid;

  always @* begin
    ale_end = latch ? (ale_sel ? `BC_ALE_WIDE : `BC_ALE_NARROW) : `BC_ZERO;
    case (kind)
      `BC_KIND_CODE: len = latch ? code_lat : code_seq;
      `BC_KIND_READ: len = latch ? read_lat : read_seq;
      default:       len = latch ? write_lat : write_seq;
    endcase
    len_hs     = {2'b00, len, 1'b0};
    hold       = hold_ext ? `BC_CLK_HS : `BC_ZERO;
    wid        = wstb_sel ? `BC_WSTB_WIDE : `BC_WSTB_NARROW;
    data_start = latch ? ale_end + `BC_HALF : `BC_ZERO;
    if (kind == `BC_KIND_WRITE) begin
      tot     = `BC_WR_BASE + len_hs;
      stb_end = tot - hold;
      // Strobe starts on a falling edge, half a clock before its full width
      if (stb_end > wid + `BC_HALF + data_start)
        stb_start = stb_end - wid - `BC_HALF;
      else
        stb_start = data_start + `BC_HALF;
    end else begin
      tot       = (latch ? `BC_LAT_BASE : `BC_SEQ_BASE) + len_hs;
      stb_end   = tot;
      stb_start = latch ? ale_end + `BC_HALF : `BC_ZERO;
    end
    wait_ok = (stb_end - stb_start) > `BC_WAIT_MIN;
  end
endmodule // bus_cycle_calc

// ### hdl/ext_bus_cycle_timing.v
// External bus cycle sequencer: latch pulse, code/read/write strobes and wait stretch
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module ext_bus_cycle_timing (
  input  wire        CORE_CLK,
  input  wire        ARST_N,
  input  wire        REQ_VALID,
  output wire        REQ_READY,
  input  wire [1:0]  REQ_KIND,
  input  wire        REQ_LATCH,
  input  wire        REQ_CHAIN,
  input  wire [1:0]  REQ_BYTE_EN,
  input  wire [23:0] REQ_ADDR,
  input  wire [15:0] REQ_WDATA,
  output reg         RESP_VALID,
  output reg  [15:0] RESP_DATA,
  output wire        BUSY,
  input  wire        LATCH_WIDTH_SEL,
  input  wire [1:0]  CODE_SEQ_CYCLE_LEN,
  input  wire [1:0]  CODE_LATCHED_CYCLE_LEN,
  input  wire [1:0]  READ_SEQ_CYCLE_LEN,
  input  wire [1:0]  READ_LATCHED_CYCLE_LEN,
  input  wire [1:0]  WRITE_SEQ_CYCLE_LEN,
  input  wire [1:0]  WRITE_LATCHED_CYCLE_LEN,
  input  wire        WRITE_HOLD_EXT,
  input  wire        WRITE_STROBE_WIDTH_SEL,
  output reg         BUS_CLOCK_REF_OUT,
  output reg         ADDR_LATCH_STROBE,
  output reg         CODE_READ_STROBE_N,
  output reg         READ_STROBE_N,
  output reg         WRITE_STROBE_LOW_N,
  output reg         WRITE_STROBE_HIGH_N,
  output reg  [23:0] BUS_ADDR,
  output reg  [15:0] AD_OUT,
  output reg         AD_OE,
  input  wire [15:0] AD_IN,
  input  wire        WAIT_IN
);
  localparam [1:0] IDLE = `BC_ST_IDLE;
  localparam [1:0] RUN  = `BC_ST_RUN;

  reg  [1:0]          state;
  reg  [`BC_HS_W-1:0] h;
  reg  [1:0]          kind;
  reg                 latch;
  reg                 chain;
  reg  [1:0]          be;
  reg  [23:0]         addr;
  reg  [15:0]         wdata;
  reg                 chain_hold;

  reg  [1:0]          next_state;
  reg  [`BC_HS_W-1:0] next_h;
  reg                 next_chain_hold;
  wire [1:0]          next_kind;
  wire                next_latch;
  wire                next_chain;
  wire [1:0]          next_be;
  wire [23:0]         next_addr;
  wire [15:0]         next_wdata;

  wire                wait_s;
  wire [15:0]         ad_s;
  wire [`BC_HS_W-1:0] c_tot;
  wire [`BC_HS_W-1:0] c_stb_end;
  wire                c_wait_ok;
  wire [`BC_HS_W-1:0] n_tot;
  wire [`BC_HS_W-1:0] n_ale_end;
  wire [`BC_HS_W-1:0] n_stb_start;
  wire [`BC_HS_W-1:0] n_stb_end;
  wire [`BC_HS_W-1:0] n_data_start;

  wire running;
  wire stb_last;
  wire stall;
  wire last;
  wire take;
  wire n_run;
  wire n_ale;
  wire n_stb;
  wire n_code;
  wire n_read;
  wire n_write;
  wire wr_low;
  wire wr_high;
  wire wr_drive;
  wire resp_take;

  // Wait and the shared data lines come from outside the core clock; two flops each
  bus_sync2 #(.W(1)) u_wait_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .d      (WAIT_IN),
    .q      (wait_s)
  );

  bus_sync2 #(.W(16)) u_ad_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .d      (AD_IN),
    .q      (ad_s)
  );

  // Timing of the cycle in progress
  bus_cycle_calc u_calc_cur (
    .kind       (kind),
    .latch      (latch),
    .ale_sel    (LATCH_WIDTH_SEL),
    .code_seq   (CODE_SEQ_CYCLE_LEN),
    .code_lat   (CODE_LATCHED_CYCLE_LEN),
    .read_seq   (READ_SEQ_CYCLE_LEN),
    .read_lat   (READ_LATCHED_CYCLE_LEN),
    .write_seq  (WRITE_SEQ_CYCLE_LEN),
    .write_lat  (WRITE_LATCHED_CYCLE_LEN),
    .hold_ext   (WRITE_HOLD_EXT),
    .wstb_sel   (WRITE_STROBE_WIDTH_SEL),
    .tot        (c_tot),
    .ale_end    (),
    .stb_start  (),
    .stb_end    (c_stb_end),
    .data_start (),
    .wait_ok    (c_wait_ok)
  );

  // Timing of the cycle that the pins show next
  bus_cycle_calc u_calc_next (
    .kind       (next_kind),
    .latch      (next_latch),
    .ale_sel    (LATCH_WIDTH_SEL),
    .code_seq   (CODE_SEQ_CYCLE_LEN),
    .code_lat   (CODE_LATCHED_CYCLE_LEN),
    .read_seq   (READ_SEQ_CYCLE_LEN),
    .read_lat   (READ_LATCHED_CYCLE_LEN),
    .write_seq  (WRITE_SEQ_CYCLE_LEN),
    .write_lat  (WRITE_LATCHED_CYCLE_LEN),
    .hold_ext   (WRITE_HOLD_EXT),
    .wstb_sel   (WRITE_STROBE_WIDTH_SEL),
    .tot        (n_tot),
    .ale_end    (n_ale_end),
    .stb_start  (n_stb_start),
    .stb_end    (n_stb_end),
    .data_start (n_data_start),
    .wait_ok    ()
  );

  assign running  = (state == RUN);
  assign BUSY     = running;
  // Last low half before the strobe ends; the next edge is a rising one
  assign stb_last = running && (h == c_stb_end - `BC_HALF);
  assign stall    = stb_last && c_wait_ok && wait_s;
  assign last     = running && (h == c_tot - `BC_HALF) && !stall;
  // Cycles start only when the reference clock is about to rise
  assign REQ_READY = ((state == IDLE) && !BUS_CLOCK_REF_OUT) || last;
  assign take      = REQ_VALID && REQ_READY;

  // A taken request replaces the snapshot of the cycle in progress
  assign next_kind  = take ? REQ_KIND : kind;
  assign next_latch = take ? REQ_LATCH : latch;
  assign next_chain = take ? REQ_CHAIN : chain;
  assign next_be    = take ? REQ_BYTE_EN : be;
  assign next_addr  = take ? REQ_ADDR : addr;
  assign next_wdata = take ? REQ_WDATA : wdata;

  always @* begin
    next_state      = state;
    next_h          = h;
    next_chain_hold = chain_hold;
    case (state)
      IDLE: begin
        if (take) begin
          next_state      = RUN;
          next_h          = `BC_ZERO;
          next_chain_hold = 1'b0;
        end
      end
      RUN: begin
        if (take) begin
          next_h          = `BC_ZERO;
          next_chain_hold = 1'b0;
        end else if (last) begin
          next_state      = IDLE;
          next_h          = `BC_ZERO;
          // A chained read leaves its strobe low until the follow-on request is taken
          next_chain_hold = chain && (kind != `BC_KIND_WRITE);
        end else if (stall) begin
          // Stepping back one half-step adds a whole bus clock and keeps the edge phase
          next_h = h - `BC_HALF;
        end else begin
          next_h = h + `BC_HALF;
        end
      end
      default: begin
        next_state      = IDLE;
        next_h          = `BC_ZERO;
        next_chain_hold = 1'b0;
      end
    endcase
  end

  // Levels of the half-step that the pins show after the coming edge
  assign n_run   = (next_state == RUN);
  assign n_ale   = n_run && (next_h < n_ale_end);
  assign n_stb   = n_run && (next_h >= n_stb_start) && (next_h < n_stb_end);
  // A chained fetch or split read keeps its strobe low into the follow-on cycle
  assign n_code  = (next_kind == `BC_KIND_CODE) && (n_stb || next_chain_hold);
  assign n_read  = (next_kind == `BC_KIND_READ) && (n_stb || next_chain_hold);
  assign n_write = (next_kind == `BC_KIND_WRITE) && n_stb;

  assign wr_low   = n_write && next_be[0];
  assign wr_high  = n_write && next_be[1];
  // Write data stays driven through the hold half-steps up to the end of the cycle
  assign wr_drive = n_run && (next_kind == `BC_KIND_WRITE)
                    && (next_h >= n_data_start);
  // Wait and read data reach this point two core cycles late through the synchronisers
  assign resp_take = stb_last && !stall && (kind != `BC_KIND_WRITE);

  // Sequencer state; settings change only while idle, so no copy of them is kept
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state      <= IDLE;
      h          <= `BC_ZERO;
      kind       <= `BC_KIND_CODE;
      latch      <= 1'b0;
      chain      <= 1'b0;
      be         <= 2'h0;
      addr       <= 24'h000000;
      wdata      <= 16'h0000;
      chain_hold <= 1'b0;
    end else begin
      state      <= next_state;
      h          <= next_h;
      kind       <= next_kind;
      latch      <= next_latch;
      chain      <= next_chain;
      be         <= next_be;
      addr       <= next_addr;
      wdata      <= next_wdata;
      chain_hold <= next_chain_hold;
    end
  end

  // Pins come from the next half-step so that they change together with h
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_CLOCK_REF_OUT   <= 1'b0;
      ADDR_LATCH_STROBE   <= 1'b0;
      CODE_READ_STROBE_N  <= 1'b1;
      READ_STROBE_N       <= 1'b1;
      WRITE_STROBE_LOW_N  <= 1'b1;
      WRITE_STROBE_HIGH_N <= 1'b1;
      BUS_ADDR            <= 24'h000000;
      AD_OUT              <= 16'h0000;
      AD_OE               <= 1'b0;
    end else begin
      BUS_CLOCK_REF_OUT   <= !BUS_CLOCK_REF_OUT;
      ADDR_LATCH_STROBE   <= n_ale;
      CODE_READ_STROBE_N  <= !n_code;
      READ_STROBE_N       <= !n_read;
      WRITE_STROBE_LOW_N  <= !wr_low;
      WRITE_STROBE_HIGH_N <= !wr_high;
      BUS_ADDR            <= next_addr;
      // Address sits on the shared lines during the latch pulse, write data after it
      AD_OUT              <= n_ale ? next_addr[15:0] : next_wdata;
      AD_OE               <= n_ale || wr_drive;
    end
  end

  // Read data is taken in the last strobe half-step and held until the next read
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RESP_VALID <= 1'b0;
      RESP_DATA  <= 16'h0000;
    end else begin
      RESP_VALID <= resp_take;
      if (resp_take)
        RESP_DATA <= ad_s;
    end
  end
endmodule // ext_bus_cycle_timing

// ### verif/ext_bus_sva.sv
// Pin-level assertions for the external bus cycle sequencer
`timescale 1ns/1ps
module ext_bus_sva (
  input wire        CORE_CLK,
  input wire        ARST_N,
  input wire        BUS_CLOCK_REF_OUT,
  input wire        ADDR_LATCH_STROBE,
  input wire        CODE_READ_STROBE_N,
  input wire        READ_STROBE_N,
  input wire        WRITE_STROBE_LOW_N,
  input wire        LATCH_WIDTH_SEL,
  input wire        AD_OE,
  input wire [15:0] AD_OUT,
  input wire [23:0] BUS_ADDR,
  input wire        RESP_VALID
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  chk_ale_rise: assert property ($rose(ADDR_LATCH_STROBE) |-> BUS_CLOCK_REF_OUT)
    else $error("latch rise off ref rise");
  chk_ale_fall: assert property ($fell(ADDR_LATCH_STROBE) |-> !BUS_CLOCK_REF_OUT)
    else $error("latch fall off ref fall");
  chk_ale_narrow: assert property ($rose(ADDR_LATCH_STROBE) && !LATCH_WIDTH_SEL |=> !ADDR_LATCH_STROBE)
    else $error("narrow latch width");
  chk_ale_wide: assert property ($rose(ADDR_LATCH_STROBE) && LATCH_WIDTH_SEL |-> ADDR_LATCH_STROBE[*3] ##1 !ADDR_LATCH_STROBE)
    else $error("wide latch width");
  chk_rd_edge: assert property ($changed(READ_STROBE_N) |-> BUS_CLOCK_REF_OUT)
    else $error("read strobe edge off ref rise");
  chk_code_edge: assert property ($changed(CODE_READ_STROBE_N) |-> BUS_CLOCK_REF_OUT)
    else $error("code strobe edge off ref rise");
  chk_wr_assert: assert property ($fell(WRITE_STROBE_LOW_N) |-> !BUS_CLOCK_REF_OUT)
    else $error("write strobe start off ref fall");
  chk_wr_release: assert property ($rose(WRITE_STROBE_LOW_N) |-> BUS_CLOCK_REF_OUT)
    else $error("write strobe end off ref rise");
  chk_ale_addr: assert property (ADDR_LATCH_STROBE |-> AD_OE && AD_OUT == BUS_ADDR[15:0])
    else $error("address not driven in latch");
  chk_rd_min: assert property ($fell(READ_STROBE_N) |=> !READ_STROBE_N)
    else $error("read strobe under one clock");
  cover property ($rose(ADDR_LATCH_STROBE) && LATCH_WIDTH_SEL);
  cover property ($fell(WRITE_STROBE_LOW_N));
  cover property (RESP_VALID);
endmodule // ext_bus_sva

bind ext_bus_cycle_timing ext_bus_sva chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
  .BUS_CLOCK_REF_OUT(BUS_CLOCK_REF_OUT), .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
  .CODE_READ_STROBE_N(CODE_READ_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
  .WRITE_STROBE_LOW_N(WRITE_STROBE_LOW_N), .LATCH_WIDTH_SEL(LATCH_WIDTH_SEL),
  .AD_OE(AD_OE), .AD_OUT(AD_OUT), .BUS_ADDR(BUS_ADDR), .RESP_VALID(RESP_VALID));

// ### verif/ext_mem_model.sv
// Far-side memory model: answers reads, keeps write data, can stall with wait
`timescale 1ns/1ps
module ext_mem_model (
  input  wire        CORE_CLK,
  input  wire        CODE_READ_STROBE_N,
  input  wire        READ_STROBE_N,
  input  wire        WRITE_STROBE_LOW_N,
  input  wire [23:0] BUS_ADDR,
  input  wire [15:0] AD_OUT,
  input  wire [3:0]  wait_len,
  output wire [15:0] AD_IN,
  output wire        WAIT_IN,
  output reg  [15:0] wdata
);
  wire       rd  = !CODE_READ_STROBE_N || !READ_STROBE_N;
  wire       act = rd || !WRITE_STROBE_LOW_N;
  reg [15:0] last = 16'h0000;
  reg [3:0]  wcnt = 4'h0;
  reg        a0_q = 1'b0;
  // Released lines show a pattern that flips every cycle, never a stale copy
  assign AD_IN   = rd ? BUS_ADDR[15:0] ^ 16'h5A3C : ~last;
  assign WAIT_IN = act && wcnt < wait_len;
  always @(posedge CORE_CLK) begin
    last <= AD_IN;
    a0_q <= BUS_ADDR[0];
    // A rising low address bit starts a new wait count where the strobe shows no edge
    wcnt <= (act && !(BUS_ADDR[0] && !a0_q)) ? wcnt + {3'h0, WAIT_IN} : 4'h0;
  end
  always @(negedge CORE_CLK) if (!WRITE_STROBE_LOW_N) wdata <= AD_OUT;
endmodule // ext_mem_model

// ### verif/tb_top.sv
// Self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module tb_top;
  typedef struct {int kind, lat, len, ale, hold, ws, tot, start, stb, hh;} row_t;
  row_t        rows [12] = '{
    '{0,0,0,0,1,0,2,0,2,0}, '{0,0,3,0,1,0,8,0,8,0}, '{0,1,0,0,1,0,4,2,2,0},
    '{0,1,3,1,1,0,10,4,6,0}, '{1,0,0,0,1,0,2,0,2,0}, '{1,0,2,0,1,0,6,0,6,0},
    '{1,1,1,0,1,0,6,2,4,0}, '{1,1,3,1,1,0,10,4,6,0}, '{2,0,0,0,0,0,4,1,3,0},
    '{2,0,3,0,1,1,10,3,5,2}, '{2,1,3,1,1,0,10,5,3,2}, '{2,1,3,0,0,1,10,5,5,0}};
  logic        CORE_CLK = 1'b0, ARST_N = 1'b0, REQ_VALID = 1'b0, REQ_LATCH = 1'b0;
  logic        REQ_CHAIN = 1'b0, ale = 1'b0, hold = 1'b1, wsel = 1'b0, mon = 1'b0;
  logic [1:0]  REQ_KIND = 2'h0, REQ_BYTE_EN = 2'h3;
  logic [1:0]  lens [6] = '{default: 2'h0};
  logic [23:0] REQ_ADDR = 24'h000000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic [3:0]  wait_len = 4'h0;
  wire         REQ_READY, RESP_VALID, BUSY, BUS_CLOCK_REF_OUT, ADDR_LATCH_STROBE, AD_OE;
  wire         CODE_READ_STROBE_N, READ_STROBE_N, WRITE_STROBE_LOW_N, WRITE_STROBE_HIGH_N, WAIT_IN;
  wire [15:0]  RESP_DATA, AD_OUT, AD_IN, wdata;
  wire [23:0]  BUS_ADDR;
  int          err_count = 0, n_tests = 0, rises = 0, low, first, resp, oe, held, wh;

  ext_bus_cycle_timing uut (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_KIND(REQ_KIND), .REQ_LATCH(REQ_LATCH), .REQ_CHAIN(REQ_CHAIN),
    .REQ_BYTE_EN(REQ_BYTE_EN), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RESP_VALID(RESP_VALID),
    .RESP_DATA(RESP_DATA), .BUSY(BUSY), .LATCH_WIDTH_SEL(ale), .CODE_SEQ_CYCLE_LEN(lens[0]),
    .CODE_LATCHED_CYCLE_LEN(lens[1]), .READ_SEQ_CYCLE_LEN(lens[2]), .READ_LATCHED_CYCLE_LEN(lens[3]),
    .WRITE_SEQ_CYCLE_LEN(lens[4]), .WRITE_LATCHED_CYCLE_LEN(lens[5]), .WRITE_HOLD_EXT(hold),
    .WRITE_STROBE_WIDTH_SEL(wsel), .BUS_CLOCK_REF_OUT(BUS_CLOCK_REF_OUT),
    .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE), .CODE_READ_STROBE_N(CODE_READ_STROBE_N),
    .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_LOW_N(WRITE_STROBE_LOW_N),
    .WRITE_STROBE_HIGH_N(WRITE_STROBE_HIGH_N), .BUS_ADDR(BUS_ADDR), .AD_OUT(AD_OUT),
    .AD_OE(AD_OE), .AD_IN(AD_IN), .WAIT_IN(WAIT_IN));
  ext_mem_model mdl (.CORE_CLK(CORE_CLK), .CODE_READ_STROBE_N(CODE_READ_STROBE_N),
    .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_LOW_N(WRITE_STROBE_LOW_N), .BUS_ADDR(BUS_ADDR),
    .AD_OUT(AD_OUT), .wait_len(wait_len), .AD_IN(AD_IN), .WAIT_IN(WAIT_IN), .wdata(wdata));

  initial forever #12.5 CORE_CLK = ~CORE_CLK;
  always @(posedge READ_STROBE_N or posedge CODE_READ_STROBE_N) if (mon) rises++;

  task automatic chk_num(input string what, input int exp, input int got);
    n_tests++;
    if (exp != got) begin
      err_count++;
      $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hold the request until the edge that takes it, then drop it
  task automatic send(input logic [1:0] k, input logic l, input logic c, input logic [23:0] a);
    int i;
    REQ_KIND = k;
    REQ_LATCH = l;
    REQ_CHAIN = c;
    REQ_ADDR = a;
    REQ_VALID = 1'b1;
    for (i = 0; i < 40 && REQ_READY !== 1'b1; i++) @(negedge CORE_CLK);
    if (i == 40) begin
      err_count++;
      finish_test();
    end
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
  endtask
  // Sample count i shows half-step i-1 of the cycle just taken
  task automatic measure(input int n, input logic [1:0] k);
    logic s;
    {low, first, resp, oe, held, wh} = '0;
    for (int i = 1; i <= n; i++) begin
      s = k == 2'h2 ? WRITE_STROBE_LOW_N : k == 2'h1 ? READ_STROBE_N : CODE_READ_STROBE_N;
      if (s === 1'b0 && first == 0) first = i;
      if (s === 1'b0) low++;
      if (WRITE_STROBE_HIGH_N === 1'b0) wh++;
      if (AD_OE === 1'b1) oe++;
      if (AD_OE === 1'b1 && low > 0 && s === 1'b1) held++;
      if (RESP_VALID === 1'b1 && resp == 0) resp = i;
      @(negedge CORE_CLK);
    end
  endtask

  initial begin
    repeat (3) @(negedge CORE_CLK);
    ARST_N = 1'b1;
    foreach (rows[r]) begin
      ale = rows[r].ale[0];
      hold = rows[r].hold[0];
      wsel = rows[r].ws[0];
      foreach (lens[j]) lens[j] = ~rows[r].len[1:0];
      lens[rows[r].kind * 2 + rows[r].lat] = rows[r].len[1:0];
      REQ_WDATA = 16'hC3A5 ^ 16'(r);
      send(rows[r].kind[1:0], rows[r].lat[0], 1'b0, 24'h120400 + 24'(r * 16));
      measure(rows[r].tot + 4, rows[r].kind[1:0]);
      chk_num("strobe start", rows[r].start + 1, first);
      chk_num("strobe width", rows[r].stb, low);
      if (rows[r].kind == 2) begin
        chk_num("drive length", rows[r].tot - rows[r].lat, oe);
        chk_num("data hold", rows[r].hh, held);
        chk_num("high strobe", low, wh);
        chk_val("write data", REQ_WDATA, wdata);
      end else begin
        chk_num("cycle length", rows[r].tot + 1, resp);
        if (rows[r].stb > 5) chk_val("read data", REQ_ADDR[15:0] ^ 16'h5A3C, RESP_DATA);
      end
      $display("row %0d done", r);
    end
    lens[2] = 2'h3;
    wait_len = 4'hC;
    send(2'h1, 1'b0, 1'b0, 24'h000200);
    measure(40, 2'h1);
    chk_num("stretched read", 1, int'(resp > 9 && resp < 30 && resp % 2 == 1));
    lens[2] = 2'h0;
    send(2'h1, 1'b0, 1'b0, 24'h000210);
    measure(12, 2'h1);
    chk_num("short read", 3, resp);
    $display("wait test done");
    wait_len = 4'h0;
    lens[3] = 2'h0;
    ale = 1'b0;
    mon = 1'b1;
    send(2'h1, 1'b1, 1'b1, 24'h000300);
    send(2'h1, 1'b0, 1'b0, 24'h000301);
    measure(6, 2'h1);
    chk_num("split strobe rises", 1, rises);
    $display("split read test done");
    rises = 0;
    lens[0] = 2'h1;
    send(2'h0, 1'b0, 1'b1, 24'h000400);
    send(2'h0, 1'b0, 1'b0, 24'h000402);
    measure(6, 2'h0);
    chk_num("burst strobe rises", 1, rises);
    chk_val("burst address", 16'h0402, BUS_ADDR[15:0]);
    $display("burst test done");
    REQ_BYTE_EN = 2'h1;
    lens[4] = 2'h1;
    wsel = 1'b0;
    hold = 1'b1;
    send(2'h2, 1'b0, 1'b0, 24'h000500);
    measure(10, 2'h2);
    chk_num("low byte strobe", 3, low);
    chk_num("high byte strobe", 0, wh);
    chk_val("low byte data", REQ_WDATA, wdata);
    $display("byte enable test done");
    send(2'h2, 1'b0, 1'b0, 24'h000600);
    ARST_N = 1'b0;
    @(negedge CORE_CLK);
    chk_val("reset pins", 16'h0078, {7'h00, BUS_CLOCK_REF_OUT, ADDR_LATCH_STROBE,
      CODE_READ_STROBE_N, READ_STROBE_N, WRITE_STROBE_LOW_N, WRITE_STROBE_HIGH_N, AD_OE, BUSY,
      RESP_VALID});
    $display("reset test done");
    finish_test();
  end
endmodule // tb_top
